//--- twsp_pkg.sv
// constants and carrier types for the three-wire serial port
package twsp_pkg;
  localparam int BUS_AW = 4;
  localparam int BUS_DW = 32;
  // register index; byte address is four times the index
  localparam logic [1:0] IDX_DATA = 2'h0;
  localparam logic [1:0] IDX_CTRL = 2'h1;
  localparam logic [1:0] IDX_STAT = 2'h2;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam int ST_OVR = 2;
  localparam logic [3:0] LAST_BIT_BYTE = 4'h7;
  localparam logic [3:0] LAST_BIT_WORD = 4'hf;
  localparam logic [4:0] LAST_EDGE_BYTE = 5'h0f;
  localparam logic [4:0] LAST_EDGE_WORD = 5'h1f;
  localparam int MSB_BYTE = 7;
  localparam int MSB_WORD = 15;

  typedef struct packed {
    logic [6:0] clk_div;
    logic idle_high;
    logic phase_alt;
    logic done_ie;
    logic rbf_ie;
    logic ovr_ie;
    logic echo;
    logic word16;
    logic master;
    logic enable;
  } twsp_ctrl_t;

  typedef struct packed {
    logic overrun_flag;
    logic read_buffer_full_flag;
    logic shifter_busy_flag;
  } twsp_stat_t;
endpackage

//--- twsp_top.sv
// three-wire serial port: avalon-mm registers, master/slave shifter, pins
`timescale 1ns/10ps
module twsp_top (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [twsp_pkg::BUS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [twsp_pkg::BUS_DW-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [twsp_pkg::BUS_DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic ss_n_i,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic irq_o
);
  import twsp_pkg::*;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [1:0] be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  // msb first; in byte mode the upper byte is left alone
  function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
                                           input logic w16);
    shift_in = w16 ? {v[14:0], b} : {v[15:8], v[6:0], b};
  endfunction

  function automatic logic top_bit(input logic [15:0] v, input logic w16);
    top_bit = w16 ? v[MSB_WORD] : v[MSB_BYTE];
  endfunction

  twsp_ctrl_t ctrl_r;
  twsp_stat_t stat_r;
  logic [15:0] shift_r;
  logic [15:0] rbuf_r;
  logic pend_r;
  logic valid_r;
  logic out_r;
  logic last_in_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic irq_r;
  logic m_run_r;
  logic [6:0] div_cnt_r;
  logic [4:0] edge_cnt_r;
  logic sck_r;
  logic sck_oe_r;
  logic mosi_oe_r;
  logic miso_oe_r;
  logic s_act_r;
  logic [3:0] bit_cnt_r;
  logic [3:0] in_s1_r;
  logic [3:0] in_s2_r;
  logic sck_s3_r;

  logic [1:0] idx;
  logic capture;
  logic commit;
  logic rd_data;
  logic wr_data;
  logic wr_ctrl;
  logic wr_stat;
  logic sck_s;
  logic ss_act;
  logic mosi_s;
  logic miso_s;
  logic m_tick;
  logic s_edge;
  logic edge_v;
  logic edge_lvl;
  logic leading;
  logic sample_e;
  logic din;
  logic s_start;
  logic in_xfer;
  logic do_sample;
  logic do_drive;
  logic complete;
  logic m_go;
  logic buf_free;
  logic echo_sel;
  logic [15:0] word_now;
  logic [3:0] last_bit;
  logic [4:0] last_edge;

  // two flops on every pin input: sck, select, mosi, miso
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      in_s1_r <= 4'h2;
      in_s2_r <= 4'h2;
      sck_s3_r <= 1'b0;
    end else begin
      in_s1_r <= {miso_i, mosi_i, ss_n_i, sck_i};
      in_s2_r <= in_s1_r;
      sck_s3_r <= in_s2_r[0];
    end
  end

  always_comb begin
    sck_s = in_s2_r[0];
    ss_act = ~in_s2_r[1];
    mosi_s = in_s2_r[2];
    miso_s = in_s2_r[3];
    idx = avs_address_i[3:2];
    // read side effects happen when data is captured, so nothing slips past
    capture = avs_read_i && wait_r;
    commit = avs_write_i && !wait_r;
    rd_data = capture && idx == IDX_DATA;
    wr_data = commit && idx == IDX_DATA;
    wr_ctrl = commit && idx == IDX_CTRL;
    wr_stat = commit && idx == IDX_STAT;
    last_bit = ctrl_r.word16 ? LAST_BIT_WORD : LAST_BIT_BYTE;
    last_edge = ctrl_r.word16 ? LAST_EDGE_WORD : LAST_EDGE_BYTE;
    m_tick = m_run_r && div_cnt_r == ctrl_r.clk_div;
    s_edge = !ctrl_r.master && ctrl_r.enable && ss_act && sck_s != sck_s3_r;
    edge_v = ctrl_r.master ? m_tick : s_edge;
    edge_lvl = ctrl_r.master ? ~sck_r : sck_s;
    leading = edge_lvl != ctrl_r.idle_high;
    sample_e = edge_lvl != ctrl_r.phase_alt;
    din = ctrl_r.master ? miso_s : mosi_s;
    s_start = s_edge && leading && !s_act_r;
    in_xfer = ctrl_r.master ? m_run_r : (s_act_r || s_start);
    do_sample = edge_v && sample_e && in_xfer;
    do_drive = edge_v && !sample_e && in_xfer;
    complete = ctrl_r.master ? (m_tick && edge_cnt_r == last_edge)
                             : (do_sample && bit_cnt_r == last_bit);
    m_go = wr_data && ctrl_r.master && ctrl_r.enable;
    word_now = do_sample ? shift_in(shift_r, din, ctrl_r.word16) : shift_r;
    buf_free = !stat_r.read_buffer_full_flag || (rd_data && !pend_r);
    echo_sel = !ctrl_r.master && ctrl_r.echo && !valid_r;
  end

  // avalon slave: one wait cycle, answer in the cycle after the request
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if ((avs_read_i || avs_write_i) && wait_r) begin
      wait_r <= 1'b0;
      if (avs_read_i) begin
        unique case (idx)
          IDX_DATA: rdata_r <= {16'h0000, rbuf_r};
          IDX_CTRL: rdata_r <= {16'h0000, ctrl_r};
          IDX_STAT: rdata_r <= {29'h0000_0000, stat_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end else begin
      wait_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_r <= twsp_ctrl_t'(CTRL_RST);
    end else if (wr_ctrl) begin
      // glitch-free clock relies on software holding enable low here
      ctrl_r <= twsp_ctrl_t'(merge16(ctrl_r, avs_writedata_i[15:0], avs_byteenable_i[1:0]));
    end
  end

  // shifter, read buffer and serial output bit
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shift_r <= DATA_RST;
      rbuf_r <= DATA_RST;
      out_r <= 1'b0;
      last_in_r <= 1'b0;
    end else begin
      if (wr_data) begin
        shift_r <= merge16(shift_r, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
      end else if (do_sample) begin
        shift_r <= word_now;
      end
      if (do_sample) begin
        last_in_r <= din;
      end
      if (ctrl_r.enable && complete && buf_free) begin
        if (ctrl_r.word16) begin
          rbuf_r <= word_now;
        end else begin
          rbuf_r[7:0] <= word_now[7:0];
        end
      end else if (ctrl_r.enable && rd_data && pend_r) begin
        if (ctrl_r.word16) begin
          rbuf_r <= shift_r;
        end else begin
          rbuf_r[7:0] <= shift_r[7:0];
        end
      end
      if (!ctrl_r.enable && ctrl_r.master) begin
        out_r <= 1'b0;
      end else if (wr_data && ctrl_r.master) begin
        // new msb must stand before the first leading edge, not the stale one
        out_r <= top_bit(merge16(shift_r, avs_writedata_i[15:0], avs_byteenable_i[1:0]),
                         ctrl_r.word16);
      end else if (!in_xfer) begin
        // msb presented ahead so the sample-first phase sees it on edge one
        out_r <= echo_sel ? mosi_s : top_bit(shift_r, ctrl_r.word16);
      end else if (do_drive) begin
        out_r <= echo_sel ? last_in_r : top_bit(shift_r, ctrl_r.word16);
      end
    end
  end

  // status flags; a hardware set wins over a clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ctrl_r.enable) begin
      stat_r <= '0;
      pend_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      if (complete) begin
        valid_r <= 1'b0;
      end
      if (wr_data) begin
        valid_r <= 1'b1;
      end
      if (rd_data && !pend_r) begin
        stat_r.read_buffer_full_flag <= 1'b0;
      end
      if (rd_data && pend_r) begin
        pend_r <= 1'b0;
        stat_r.shifter_busy_flag <= 1'b0;
      end
      if (complete) begin
        if (buf_free) begin
          stat_r.read_buffer_full_flag <= 1'b1;
          stat_r.shifter_busy_flag <= 1'b0;
        end else begin
          pend_r <= 1'b1;
        end
      end
      if (m_go || s_start) begin
        pend_r <= 1'b0;
      end
      if (wr_data || s_start) begin
        stat_r.shifter_busy_flag <= 1'b1;
      end
      if (wr_stat && avs_byteenable_i[0] && avs_writedata_i[ST_OVR]) begin
        stat_r.overrun_flag <= 1'b0;
      end
      if (m_go && stat_r.read_buffer_full_flag && pend_r) begin
        stat_r.overrun_flag <= 1'b1;
      end
    end
  end

  // master clock generator: half period is divider plus one system clocks
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      m_run_r <= 1'b0;
      div_cnt_r <= 7'h00;
      edge_cnt_r <= 5'h00;
      sck_r <= 1'b0;
    end else if (!ctrl_r.enable || !ctrl_r.master) begin
      m_run_r <= 1'b0;
      div_cnt_r <= 7'h00;
      edge_cnt_r <= 5'h00;
      sck_r <= ctrl_r.idle_high;
    end else if (m_go) begin
      m_run_r <= 1'b1;
      div_cnt_r <= 7'h00;
      edge_cnt_r <= 5'h00;
      sck_r <= ctrl_r.idle_high;
    end else if (m_run_r) begin
      if (m_tick) begin
        div_cnt_r <= 7'h00;
        sck_r <= ~sck_r;
        edge_cnt_r <= edge_cnt_r + 5'h01;
        if (complete) begin
          m_run_r <= 1'b0;
        end
      end else begin
        div_cnt_r <= div_cnt_r + 7'h01;
      end
    end else begin
      sck_r <= ctrl_r.idle_high;
    end
  end

  // slave bit counter; dropping select resynchronises the count
  always_ff @(posedge mclk_i) begin
    if (srst_i || !ctrl_r.enable || ctrl_r.master || !ss_act) begin
      s_act_r <= 1'b0;
      bit_cnt_r <= 4'h0;
    end else begin
      if (s_start) begin
        s_act_r <= 1'b1;
        bit_cnt_r <= 4'h0;
      end
      if (do_sample) begin
        if (complete) begin
          s_act_r <= 1'b0;
          bit_cnt_r <= 4'h0;
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
    end
  end

  // pin enables and interrupt, registered
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sck_oe_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      sck_oe_r <= ctrl_r.master;
      mosi_oe_r <= ctrl_r.master;
      miso_oe_r <= !ctrl_r.master && ctrl_r.enable && ss_act;
      irq_r <= ctrl_r.enable && ((ctrl_r.ovr_ie && stat_r.overrun_flag && ctrl_r.master)
                                 || (ctrl_r.rbf_ie && stat_r.read_buffer_full_flag)
                                 || (ctrl_r.done_ie && !stat_r.shifter_busy_flag));
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign sck_o = sck_r;
  assign sck_oe_o = sck_oe_r;
  assign mosi_o = out_r;
  assign mosi_oe_o = mosi_oe_r;
  assign miso_o = out_r;
  assign miso_oe_o = miso_oe_r;
  assign irq_o = irq_r;
endmodule

//--- twsp_sva.sv
// checker for the serial port top, bound below
`timescale 1ns/10ps
module twsp_sva (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic miso_oe_o,
  input wire logic mosi_o,
  input wire logic mosi_oe_o,
  input wire logic irq_o
);
  logic [15:0] ctl_r;
  logic [1:0] age_r;
  logic [5:0] edg_r;
  logic sck_r;
  wire wr_ok = avs_write_i && !avs_waitrequest_o;
  wire ctl_wr = wr_ok && avs_address_i[3:2] == 2'h1;
  wire dat_wr = wr_ok && avs_address_i[3:2] == 2'h0;
  wire calm = age_r == 2'h3;
  // settle window lets registered pins follow a control write
  always_ff @(posedge mclk_i) begin
    if (srst_i || ctl_wr) begin
      age_r <= 2'h0;
    end else if (!calm) begin
      age_r <= age_r + 2'h1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ctl_r <= 16'h0000;
    end else if (ctl_wr) begin
      ctl_r <= avs_writedata_i[15:0];
    end
  end
  always_ff @(posedge mclk_i) begin
    sck_r <= sck_o;
    if (srst_i || ctl_wr || dat_wr) begin
      edg_r <= 6'h00;
    end else if (sck_o != sck_r) begin
      edg_r <= edg_r + 6'h01;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    dat_wr && calm && ctl_r[1:0] == 2'h3;
  endsequence
  sequence s_toggle;
    calm && ctl_r[1:0] == 2'h3 && ctl_r[15:9] >= 7'h03 && $changed(sck_o);
  endsequence
  property p_wait_cause;
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
  endproperty
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i[3:2] == 2'h3 |-> avs_readdata_o == 32'h0;
  endproperty
  property p_off;
    calm && !ctl_r[0] |-> !irq_o && !miso_oe_o && (!ctl_r[1] || (sck_o == ctl_r[8] && !mosi_o));
  endproperty
  property p_role;
    calm |-> sck_oe_o == ctl_r[1] && mosi_oe_o == ctl_r[1];
  endproperty
  property p_count;
    calm |-> edg_r <= (ctl_r[2] ? 6'd32 : 6'd16);
  endproperty
  property p_half;
    s_toggle |=> $stable(sck_o) [*3];
  endproperty
  property p_go;
    s_start |-> ##[1:300] $changed(sck_o);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("ack without request");
  a_wait_one: assert property (p_wait_one) else $error("ack longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_off: assert property (p_off) else $error("disabled pins wrong");
  a_role: assert property (p_role) else $error("pin direction wrong");
  a_count: assert property (p_count) else $error("too many clock edges");
  a_half: assert property (p_half) else $error("half period too short");
  a_go: assert property (p_go) else $error("write started no clock");
endmodule
bind twsp_top twsp_sva i_sva (.mclk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .sck_o, .sck_oe_o, .miso_oe_o,
  .mosi_o, .mosi_oe_o, .irq_o);

//--- twsp_slave_dev.sv
// external serial slave answering master transfers
`timescale 1ns/10ps
module twsp_slave_dev (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic load_i,
  input wire logic w16_i,
  input wire logic [15:0] tx_i,
  output logic miso_o,
  output logic [15:0] rx_o
);
  logic [15:0] sr = 16'h0000;
  int left = 0;
  initial begin
    miso_o = 1'b0;
    rx_o = 16'h0000;
  end
  always @(posedge load_i) begin
    sr = w16_i ? tx_i : {tx_i[7:0], 8'h00};
    left = w16_i ? 16 : 8;
    miso_o = sr[15];
  end
  always @(posedge sck_i) rx_o = {rx_o[14:0], mosi_i};
  // after the last bit the line is not held, so it flips
  always @(negedge sck_i) begin
    sr = sr << 1;
    left = left - 1;
    miso_o = left > 0 ? sr[15] : ~miso_o;
  end
endmodule

//--- testbench.sv
// self-checking bench for the three-wire serial port
`timescale 1ns/10ps
module testbench;
  import twsp_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, sck_o, sck_oe_o, miso_i, miso_o, miso_oe_o;
  logic mosi_o, mosi_oe_o, irq_o, ld = 1'b0, w16 = 1'b0;
  logic [15:0] tx = 16'h0, rx, d, rb = 16'h0;
  logic [31:0] q, seed = 32'h7dfb9b0e;
  int num_errors = 0;
  int total_checks = 0;
  twsp_top i_dut (.mclk_i, .srst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
    .sck_i(1'b0), .sck_o, .sck_oe_o, .ss_n_i(1'b1), .miso_i, .miso_o, .miso_oe_o,
    .mosi_i(1'b0), .mosi_o, .mosi_oe_o, .irq_o);
  twsp_slave_dev i_dev (.sck_i(sck_o), .mosi_i(mosi_o), .load_i(ld), .w16_i(w16),
    .tx_i(tx), .miso_o(miso_i), .rx_o(rx));
  initial forever #10 mclk_i = ~mclk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [1:0] a, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge mclk_i);
    avs_address_i <= {a, 2'h0};
    avs_read_i <= ~w;
    avs_write_i <= w;
    avs_writedata_i <= {16'h0, v};
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    acc(1'b0, a, 16'h0);
    chk(q, exp);
  endtask
  task automatic cfg(input logic [15:0] v);
    acc(1'b1, IDX_CTRL, v & 16'hfffe);
    acc(1'b1, IDX_CTRL, v);
    rd(IDX_CTRL, {16'h0, v});
  endtask
  task automatic xfer;
    seed = lfsr(seed);
    d = seed[15:0];
    tx <= seed[31:16];
    ld <= 1'b1;
    @(posedge mclk_i);
    ld <= 1'b0;
    acc(1'b1, IDX_DATA, d);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      acc(1'b0, IDX_STAT, 16'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 100);
  endtask
  initial begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    rd(IDX_CTRL, 32'h0);
    rd(IDX_STAT, 32'h0);
    rd(IDX_DATA, 32'h0);
    acc(1'b1, 2'h3, 16'hffff);
    rd(2'h3, 32'h0);
    for (int k = 0; k < 2; k++) begin
      w16 <= k[0];
      cfg(16'h0603 | 16'(k * 36));
      xfer();
      wait_idle();
      rb = k ? tx : {rb[15:8], tx[7:0]};
      chk({31'h0, irq_o}, k);
      rd(IDX_STAT, 32'h2);
      chk(rx & (k ? 16'hffff : 16'h00ff), d & (k ? 16'hffff : 16'h00ff));
      rd(IDX_DATA, {16'h0, rb});
      rd(IDX_STAT, 32'h0);
    end
    w16 <= 1'b0;
    cfg(16'h0613);
    xfer();
    wait_idle();
    xfer();
    repeat (120) @(posedge mclk_i);
    rd(IDX_STAT, 32'h3);
    xfer();
    rd(IDX_STAT, 32'h7);
    chk({31'h0, irq_o}, 32'h1);
    acc(1'b1, IDX_STAT, 16'h0);
    rd(IDX_STAT, 32'h7);
    acc(1'b1, IDX_STAT, 16'h4);
    rd(IDX_STAT, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    acc(1'b1, IDX_CTRL, 16'h0612);
    rd(IDX_STAT, 32'h0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    give_verdict();
  end
endmodule
